// *** hdl/eih_pkg.sv ***
// eih_pkg: constants shared by the interrupt handler files
// assumes one 200 MHz clock and an 8-bit register port
package eih_pkg;
	// ----------------------------------------
	// sources and vectors
	// ----------------------------------------
	localparam int unsigned NSRC = 12; // number of interrupt sources
	localparam logic [3:0] SRC_EXT0 = 4'h0; // external input 0
	localparam logic [3:0] SRC_TMR0 = 4'h1; // timer 0 overflow
	localparam logic [3:0] SRC_EXT1 = 4'h2; // external input 1
	localparam logic [3:0] SRC_TMR1 = 4'h3; // timer 1 overflow
	localparam logic [11:0] HW_CLEAR_MASK = 12'h00F; // flags cleared on vectoring
	localparam logic [15:0] VEC_BASE = 16'h0003; // vector of source 0
	localparam logic [15:0] VEC_STEP = 16'h0008; // spacing between vectors
	// ----------------------------------------
	// timing in system clocks
	// ----------------------------------------
	localparam logic [2:0] LONG_CALL_INSTR_CYCLES = 3'h4; // forced long call length
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_TIMER_CTRL = 8'h88;
	localparam logic [7:0] OFF_IRQ_EN = 8'hA8;
	localparam logic [7:0] OFF_IRQ_PRIO = 8'hB8;
	localparam logic [7:0] OFF_PIN_CFG = 8'hE4;
	localparam logic [7:0] OFF_EXT_EN = 8'hE6;
	localparam logic [7:0] OFF_PENDING = 8'hE8;
	localparam logic [7:0] OFF_STATUS = 8'hE9;
	localparam logic [7:0] OFF_EXT_PRIO = 8'hF6;
	// ----------------------------------------
	// reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00; // every register clears at reset except the pin synchronisers, which preset high
	localparam logic [7:0] PRIO_UNUSED = 8'hC0; // upper bits of the B8 priority register read as ones; the F6 one reads them as zeros
	localparam int unsigned EA_BIT = 7; // global enable in enable register
	localparam int unsigned EXT0_SENSE_BIT = 0;
	localparam int unsigned EXT0_FLAG_BIT = 1;
	localparam int unsigned EXT1_SENSE_BIT = 2;
	localparam int unsigned EXT1_FLAG_BIT = 3;
	localparam int unsigned TMR0_FLAG_BIT = 5;
	localparam int unsigned TMR1_FLAG_BIT = 7;
	localparam int unsigned EXT0_PIN_LSB = 0; // 3-bit pin select
	localparam int unsigned EXT0_POL_BIT = 3;
	localparam int unsigned EXT1_PIN_LSB = 4;
	localparam int unsigned EXT1_POL_BIT = 7;

	// vector address of a source index
	function automatic logic [15:0] vec_of(input logic [3:0] idx);
		vec_of = VEC_BASE + VEC_STEP * {12'h000, idx};
	endfunction
endpackage

// *** hdl/eih_arb_if.sv ***
// eih_arb_if: request bundle between the handler core and its arbiter
// assumes both ends sit on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface eih_arb_if;
	logic [11:0] req; // enabled pending requests
	logic [11:0] prio; // one means high priority
	logic hi_act; // a high level routine runs
	logic lo_act; // a low level routine runs
	logic grant; // a request may be taken
	logic [3:0] idx; // winning source
	logic hi; // winner is high priority
	modport ctl(output req, prio, hi_act, lo_act, input grant, idx, hi);
	modport arb(input req, prio, hi_act, lo_act, output grant, idx, hi);
endinterface // eih_arb_if
`default_nettype wire

// *** hdl/eih_arbiter.sv ***
// eih_arbiter: two-level fixed-order priority decode
// assumes requests are already masked by all enables
`timescale 1ns/1ps
`default_nettype none
module eih_arbiter (
	eih_arb_if.arb bus
);
	// lowest set index wins within one level
	function automatic logic [4:0] first_set(input logic [11:0] v);
		first_set = 5'h00;
		for (int i = eih_pkg::NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = {1'b1, 4'(i)};
			end
		end
	endfunction

	logic [4:0] hi_pick; // {found, index} among high requests
	logic [4:0] lo_pick; // {found, index} among low requests

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// a high request pre-empts a low routine, nothing pre-empts high
	always_comb begin
		hi_pick = first_set(bus.req & bus.prio);
		lo_pick = first_set(bus.req & ~bus.prio);
		bus.grant = 1'b0;
		bus.idx = 4'h0;
		bus.hi = 1'b0;
		if (hi_pick[4] && !bus.hi_act) begin
			bus.grant = 1'b1;
			bus.idx = hi_pick[3:0];
			bus.hi = 1'b1;
		end else if (lo_pick[4] && !bus.hi_act && !bus.lo_act) begin
			bus.grant = 1'b1;
			bus.idx = lo_pick[3:0];
		end
	end
endmodule // eih_arbiter
`default_nettype wire

// *** hdl/eih_ext_sense.sv ***
// eih_ext_sense: one external request input with pin select
// assumes the port pins are free-running levels of any phase
`timescale 1ns/1ps
`default_nettype none
module eih_ext_sense (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] pins,
	input wire logic [2:0] pin_sel,
	input wire logic polarity,
	input wire logic sense,
	input wire logic sw_wr,
	input wire logic sw_val,
	input wire logic vec_clr,
	output logic flag
);
	logic sync1_reg; // first stage, read only by the second
	logic sync2_reg; // synchronised pin level
	logic act_prev_reg; // previous active level
	logic edge_flag_reg; // pending flag in edge mode
	logic active; // pin at its active level
	logic rise; // inactive to active change

	// ----------------------------------------
	// synchroniser
	// ----------------------------------------
	// pin is only watched, so the crossbar owner keeps it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			// idle level of an active-low pin, so no false level or edge follows reset
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= pins[pin_sel];
			sync2_reg <= sync1_reg;
		end
	end

	// polarity one is active high
	assign active = polarity ? sync2_reg : ~sync2_reg;
	assign rise = active & ~act_prev_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			act_prev_reg <= 1'b0;
		end else begin
			act_prev_reg <= active;
		end
	end

	// ----------------------------------------
	// pending flag
	// ----------------------------------------
	// an edge beats a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			edge_flag_reg <= 1'b0;
		end else if (!sense) begin
			edge_flag_reg <= 1'b0;
		end else if (rise) begin
			edge_flag_reg <= 1'b1;
		end else if (sw_wr) begin
			edge_flag_reg <= sw_val;
		end else if (vec_clr) begin
			edge_flag_reg <= 1'b0;
		end
	end

	// level mode simply follows the pin
	assign flag = sense ? edge_flag_reg : active;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	edge_auto_clear_a: assert property (
		sense && vec_clr && !sw_wr && !rise |=> !flag || !sense)
		else $error("edge flag not cleared on vectoring");
	level_follow_a: assert property (
		!sense |-> flag == (polarity ? sync2_reg : ~sync2_reg))
		else $error("level flag does not follow pin");
endmodule // eih_ext_sense
`default_nettype wire

// *** hdl/eih_top.sv ***
// eih_top: interrupt handler of an 8051-style core
// assumes the sequencer reports instruction ends and return_from_irq_instr,
// and peripherals give one-cycle pulses when their event occurs
`timescale 1ns/1ps
`default_nettype none

module eih_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] port_pins,
	input wire logic [11:0] periph_set,
	input wire logic core_instr_end,
	input wire logic core_next_multi,
	input wire logic core_return_from_irq_instr,
	output logic irq_call,
	output logic [15:0] irq_vector
);
	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	logic [7:0] ie_reg; // global enable, flag, enables 5..0
	logic [5:0] eie_reg; // enables of sources 11..6
	logic [5:0] ip_reg; // priorities of sources 5..0
	logic [5:0] eip_reg; // priorities of sources 11..6
	logic [7:0] timer_control_reg_reg; // timer control; ext flags live outside
	logic [7:0] pincfg_reg; // pin selects and polarities
	logic [11:4] pend_reg; // peripheral pending flags
	logic grace_reg; // enable was cleared in this instruction
	logic return_from_irq_instr_hold_reg; // the one instruction after return_from_irq_instr is running
	logic hi_act_reg; // high level routine in service
	logic lo_act_reg; // low level routine in service
	logic [2:0] call_cnt_reg; // cycles left of the long call
	logic [3:0] idx_reg; // last vectored source
	logic [15:0] vector_reg; // last vector address
	logic [7:0] rdata_reg; // read data, one cycle after the strobe

	// ----------------------------------------
	// decode and combinational terms
	// ----------------------------------------
	logic wr_ie, wr_eie, wr_ip, wr_eip, wr_timer_control_reg, wr_pin, wr_pend;
	logic ext0_flag, ext1_flag; // external pending flags
	logic [11:0] pend; // all pending flags
	logic [11:0] en; // individual enables
	logic clr_now; // this write clears the global enable
	logic ea_eff; // global enable as the arbiter sees it
	logic take; // vector now
	logic [11:0] vec_clr; // hardware clears on vectoring
	logic return_from_irq_instr_end; // a return_from_irq_instr completes now

	eih_arb_if arb ();

	assign wr_ie = reg_wr && reg_addr == eih_pkg::OFF_IRQ_EN;
	assign wr_eie = reg_wr && reg_addr == eih_pkg::OFF_EXT_EN;
	assign wr_ip = reg_wr && reg_addr == eih_pkg::OFF_IRQ_PRIO;
	assign wr_eip = reg_wr && reg_addr == eih_pkg::OFF_EXT_PRIO;
	assign wr_timer_control_reg = reg_wr && reg_addr == eih_pkg::OFF_TIMER_CTRL;
	assign wr_pin = reg_wr && reg_addr == eih_pkg::OFF_PIN_CFG;
	assign wr_pend = reg_wr && reg_addr == eih_pkg::OFF_PENDING;
	assign return_from_irq_instr_end = core_instr_end && core_return_from_irq_instr;

	// twelve flags in fixed source order
	assign pend = {pend_reg, timer_control_reg_reg[eih_pkg::TMR1_FLAG_BIT], ext1_flag,
		timer_control_reg_reg[eih_pkg::TMR0_FLAG_BIT], ext0_flag};
	assign en = {eie_reg, ie_reg[5:0]};

	// a clear of the enable still lets a request through
	// only if the next instruction is a single-cycle one
	assign clr_now = wr_ie && !reg_wdata[eih_pkg::EA_BIT] && ie_reg[eih_pkg::EA_BIT];
	// the clearing cycle itself already counts as the grace window
	assign ea_eff = (ie_reg[eih_pkg::EA_BIT] && !clr_now)
		|| ((grace_reg || clr_now) && !core_next_multi);

	// disabled flags are ignored, enable bit 7 masks all
	assign arb.req = pend & en & {12{ea_eff}};
	assign arb.prio = {eip_reg, ip_reg};
	assign arb.hi_act = hi_act_reg;
	assign arb.lo_act = lo_act_reg;

	// requests decode every clock; the call begins at an instruction end,
	// never at return_from_irq_instr's own end, so exactly one more instruction runs first
	assign take = core_instr_end && !core_return_from_irq_instr
		&& call_cnt_reg == 3'h0 && arb.grant;
	assign vec_clr = take ? (12'h001 << arb.idx) & eih_pkg::HW_CLEAR_MASK : 12'h000;
	assign irq_call = call_cnt_reg != 3'h0;
	assign irq_vector = vector_reg;
	assign reg_rdata = rdata_reg;

	eih_arbiter u_arb (
		.bus(arb)
	);

	// ----------------------------------------
	// external inputs
	// ----------------------------------------
	eih_ext_sense u_ext0 (
		.sys_clk(sys_clk),
		.rst(rst),
		.pins(port_pins),
		.pin_sel(pincfg_reg[eih_pkg::EXT0_PIN_LSB +: 3]),
		.polarity(pincfg_reg[eih_pkg::EXT0_POL_BIT]),
		.sense(timer_control_reg_reg[eih_pkg::EXT0_SENSE_BIT]),
		.sw_wr(wr_timer_control_reg),
		.sw_val(reg_wdata[eih_pkg::EXT0_FLAG_BIT]),
		.vec_clr(vec_clr[eih_pkg::SRC_EXT0]),
		.flag(ext0_flag)
	);

	eih_ext_sense u_ext1 (
		.sys_clk(sys_clk),
		.rst(rst),
		.pins(port_pins),
		.pin_sel(pincfg_reg[eih_pkg::EXT1_PIN_LSB +: 3]),
		.polarity(pincfg_reg[eih_pkg::EXT1_POL_BIT]),
		.sense(timer_control_reg_reg[eih_pkg::EXT1_SENSE_BIT]),
		.sw_wr(wr_timer_control_reg),
		.sw_val(reg_wdata[eih_pkg::EXT1_FLAG_BIT]),
		.vec_clr(vec_clr[eih_pkg::SRC_EXT1]),
		.flag(ext1_flag)
	);

	// ----------------------------------------
	// enable and priority registers
	// ----------------------------------------
	// the stored enable reads zero at once after a clear,
	// even when the grace window lets a request through
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ie_reg <= eih_pkg::RST_BYTE;
			eie_reg <= 6'h00;
			ip_reg <= 6'h00;
			eip_reg <= 6'h00;
			pincfg_reg <= eih_pkg::RST_BYTE;
		end else begin
			if (wr_ie) begin
				ie_reg <= reg_wdata;
			end
			if (wr_eie) begin
				eie_reg <= reg_wdata[5:0];
			end
			if (wr_ip) begin
				ip_reg <= reg_wdata[5:0];
			end
			if (wr_eip) begin
				eip_reg <= reg_wdata[5:0];
			end
			if (wr_pin) begin
				pincfg_reg <= reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// timer control and timer flags
	// ----------------------------------------
	// timer flags clear on vectoring; an event in the same cycle wins
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timer_control_reg_reg <= eih_pkg::RST_BYTE;
		end else begin
			if (wr_timer_control_reg) begin
				timer_control_reg_reg <= reg_wdata;
			end
			if (vec_clr[eih_pkg::SRC_TMR0]) begin
				timer_control_reg_reg[eih_pkg::TMR0_FLAG_BIT] <= 1'b0;
			end
			if (vec_clr[eih_pkg::SRC_TMR1]) begin
				timer_control_reg_reg[eih_pkg::TMR1_FLAG_BIT] <= 1'b0;
			end
			if (periph_set[eih_pkg::SRC_TMR0]) begin
				timer_control_reg_reg[eih_pkg::TMR0_FLAG_BIT] <= 1'b1;
			end
			if (periph_set[eih_pkg::SRC_TMR1]) begin
				timer_control_reg_reg[eih_pkg::TMR1_FLAG_BIT] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// peripheral pending flags
	// ----------------------------------------
	// never cleared by vectoring: the routine clears them itself
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend_reg <= 8'h00;
		end else begin
			if (wr_pend) begin
				pend_reg <= reg_wdata;
			end
			for (int i = 4; i < eih_pkg::NSRC; i++) begin
				if (periph_set[i]) begin
					pend_reg[i] <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// sequencing state
	// ----------------------------------------
	// grace lasts until the clearing instruction ends
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			grace_reg <= 1'b0;
		end else if (core_instr_end) begin
			grace_reg <= 1'b0;
		end else if (clr_now) begin
			grace_reg <= 1'b1;
		end
	end

	// marks the one instruction that runs after return_from_irq_instr, before a new call
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			return_from_irq_instr_hold_reg <= 1'b0;
		end else if (core_instr_end) begin
			return_from_irq_instr_hold_reg <= core_return_from_irq_instr;
		end
	end

	// in-service levels; return_from_irq_instr retires the higher one first
	// so execution resumes where it was interrupted
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hi_act_reg <= 1'b0;
			lo_act_reg <= 1'b0;
		end else if (take) begin
			if (arb.hi) begin
				hi_act_reg <= 1'b1;
			end else begin
				lo_act_reg <= 1'b1;
			end
		end else if (return_from_irq_instr_end) begin
			if (hi_act_reg) begin
				hi_act_reg <= 1'b0;
			end else begin
				lo_act_reg <= 1'b0;
			end
		end
	end

	// long call: vector and count load on the taking cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			call_cnt_reg <= 3'h0;
			idx_reg <= 4'h0;
			vector_reg <= 16'h0000;
		end else if (take) begin
			call_cnt_reg <= eih_pkg::LONG_CALL_INSTR_CYCLES;
			idx_reg <= arb.idx;
			vector_reg <= eih_pkg::vec_of(arb.idx);
		end else if (call_cnt_reg != 3'h0) begin
			call_cnt_reg <= call_cnt_reg - 3'h1;
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	// data stand one cycle only; unmapped offsets read zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				eih_pkg::OFF_IRQ_EN: rdata_reg <= ie_reg;
				eih_pkg::OFF_EXT_EN: rdata_reg <= {2'b00, eie_reg};
				eih_pkg::OFF_IRQ_PRIO: rdata_reg <= eih_pkg::PRIO_UNUSED | {2'b00, ip_reg};
				eih_pkg::OFF_EXT_PRIO: rdata_reg <= {2'b00, eip_reg};
				eih_pkg::OFF_PIN_CFG: rdata_reg <= pincfg_reg;
				eih_pkg::OFF_PENDING: rdata_reg <= pend_reg;
				eih_pkg::OFF_STATUS: rdata_reg <= {hi_act_reg, lo_act_reg, grace_reg, return_from_irq_instr_hold_reg, idx_reg};
				eih_pkg::OFF_TIMER_CTRL: rdata_reg <= {timer_control_reg_reg[7:4], ext1_flag,
					timer_control_reg_reg[2], ext0_flag, timer_control_reg_reg[0]};
				default: rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence call_run_s;
		irq_call [*4] ##1 !irq_call;
	endsequence

	call_length_a: assert property (take |=> call_run_s)
		else $error("long call is not four cycles");
	vector_addr_a: assert property (take |=> irq_vector == eih_pkg::vec_of($past(arb.idx)))
		else $error("wrong vector address");
	masked_none_a: assert property (take |-> en[arb.idx] && pend[arb.idx])
		else $error("vectored to a disabled source");
	global_mask_a: assert property (
		!ie_reg[eih_pkg::EA_BIT] && !grace_reg && !clr_now |-> !take)
		else $error("taken with global enable off");
	multi_block_a: assert property (
		(clr_now || !ie_reg[eih_pkg::EA_BIT]) && core_next_multi |-> !take)
		else $error("taken before a multi-cycle instruction");
	ea_reads_zero_a: assert property (
		clr_now |=> !ie_reg[eih_pkg::EA_BIT])
		else $error("global enable not cleared");
	return_from_irq_instr_gap_a: assert property (return_from_irq_instr_end |-> !take)
		else $error("call taken at the return's own end");
	return_from_irq_instr_reenter_a: assert property (
		return_from_irq_instr_hold_reg && core_instr_end && arb.grant && call_cnt_reg == 3'h0 |-> take)
		else $error("no re-entry after one instruction");
	hi_nopreempt_a: assert property (hi_act_reg |-> !take)
		else $error("high routine pre-empted");
	tmr_hw_clear_a: assert property (
		take && arb.idx == eih_pkg::SRC_TMR0 && !periph_set[eih_pkg::SRC_TMR0]
		|=> !timer_control_reg_reg[eih_pkg::TMR0_FLAG_BIT])
		else $error("timer flag not cleared on vectoring");
	periph_keep_a: assert property (
		take && arb.idx >= 4'h4 && !wr_pend |=> pend_reg[$past(arb.idx)])
		else $error("peripheral flag cleared by hardware");
	set_wins_a: assert property (periph_set[4] |=> pend_reg[4])
		else $error("event lost against a clear");
	sw_set_a: assert property (wr_pend && reg_wdata[0] |=> pend_reg[4])
		else $error("software set did not pend");
endmodule // eih_top
`default_nettype wire

// *** verif/eih_core_model.sv ***
// eih_core_model: behavioural core sequencer facing the handler
// assumes the handler's clock and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module eih_core_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] gap, // cycles per instruction minus one
	input wire logic return_from_irq_instr_req, // pulse: queue a return instruction
	input wire logic irq_call,
	output logic core_instr_end,
	output logic core_next_multi,
	output logic core_return_from_irq_instr
);
	logic [1:0] cnt_reg; // cycles into the current instruction
	logic pend_reg; // a return waits for the next instruction end
	logic fire; // the instruction ends now
	// the core stalls while the forced call runs, like the real one
	assign fire = (cnt_reg >= gap) && (irq_call !== 1'b1);
	// ----------------------------------------
	// instruction pacing
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_reg <= 2'h0;
			core_instr_end <= 1'b0;
			core_next_multi <= 1'b0;
			core_return_from_irq_instr <= 1'b0;
		end else begin
			cnt_reg <= fire ? 2'h0 : (irq_call ? cnt_reg : cnt_reg + 2'h1);
			core_instr_end <= fire;
			core_next_multi <= gap[1]; // slow pacing means long instructions
			core_return_from_irq_instr <= fire && pend_reg;
		end
	end
	// ----------------------------------------
	// queued return
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pend_reg <= 1'b0;
		end else if (return_from_irq_instr_req) begin
			pend_reg <= 1'b1;
		end else if (fire) begin
			pend_reg <= 1'b0;
		end
	end
endmodule // eih_core_model
`default_nettype wire

// *** verif/testbench.sv ***
// testbench: self-checking run of the interrupt handler
// assumes eih_top and the core model on one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] port_pins = 8'hFF; // idle high: inactive for active-low
	logic [11:0] periph_set = 12'h000;
	logic core_instr_end, core_next_multi, core_return_from_irq_instr, irq_call;
	logic [15:0] irq_vector;
	logic [1:0] gap = 2'h0;
	logic return_from_irq_instr_req = 1'b0;
	logic rd_d = 1'b0;
	logic call_d = 1'b0;
	logic [7:0] call_len = 8'h00;
	logic [7:0] rq[$]; // expected read data
	logic [15:0] vq[$]; // expected vectors
	int err_count = 0;
	int comparisons = 0;
	int seed = 30;
	logic [31:0] r;
	logic [3:0] idx;
	logic [2:0] p;
	initial forever #2.5 sys_clk = ~sys_clk;
	eih_top u_eih_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_pins(port_pins),
		.periph_set(periph_set), .core_instr_end(core_instr_end), .core_next_multi(core_next_multi),
		.core_return_from_irq_instr(core_return_from_irq_instr), .irq_call(irq_call), .irq_vector(irq_vector));
	eih_core_model u_eih_core_model (.sys_clk(sys_clk), .rst(rst), .gap(gap), .return_from_irq_instr_req(return_from_irq_instr_req),
		.irq_call(irq_call), .core_instr_end(core_instr_end), .core_next_multi(core_next_multi),
		.core_return_from_irq_instr(core_return_from_irq_instr));
	// ----------------------------------------
	// compare and verdict
	// ----------------------------------------
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("errors=%0d compares=%0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// output watcher: each result takes the oldest note
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (rd_d) chk_reg(reg_rdata, rq.pop_front());
		if (irq_call === 1'b1 && call_d !== 1'b1) begin
			if (vq.size() == 0) chk_vec(irq_vector, 16'hFFFF); // no call was due
			else chk_vec(irq_vector, vq.pop_front());
		end
		if (call_d === 1'b1 && irq_call !== 1'b1) chk_reg(call_len, 8'h04);
		call_len <= (irq_call === 1'b1) ? call_len + 8'h01 : 8'h00;
		call_d <= irq_call;
		rd_d <= reg_rd;
	end
	// ----------------------------------------
	// bus and core tasks; one idle cycle between strobes
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		rq.push_back(exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic wait_call();
		int n;
		n = 0;
		while (irq_call !== 1'b1 && n < 64) begin
			@(posedge sys_clk);
			n++;
		end
		while (irq_call === 1'b1) @(posedge sys_clk);
	endtask
	task automatic ret();
		@(posedge sys_clk);
		return_from_irq_instr_req <= 1'b1;
		@(posedge sys_clk);
		return_from_irq_instr_req <= 1'b0;
		wait_call();
	endtask
	// flag pends one cycle before software clears the global enable
	task automatic clr_race(input logic [1:0] g);
		gap <= g;
		wr(8'hA8, 8'h90);
		@(posedge sys_clk);
		periph_set <= 12'h010;
		@(posedge sys_clk);
		periph_set <= 12'h000;
		reg_wr <= 1'b1;
		reg_addr <= 8'hA8;
		reg_wdata <= 8'h10; // slow pacing keeps the long-opcode advice
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		wait_call();
		rd(8'hA8, 8'h10);
		rd(8'hE8, 8'h01);
		wr(8'hE8, 8'h00);
		ret();
	endtask
	// ----------------------------------------
	// watchdog: whole run needs about a thousand cycles
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		print_verdict();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'hA8, 8'h00);
		rd(8'hB8, 8'hC0);
		rd(8'h55, 8'h00);
		// disabled source latches but never calls
		@(posedge sys_clk);
		periph_set <= 12'h010;
		@(posedge sys_clk);
		periph_set <= 12'h000;
		rd(8'hE8, 8'h01);
		wr(8'hA8, 8'h10);
		wait_call();
		// enable takes it; flag left set re-enters after the return
		vq.push_back(16'h0023);
		vq.push_back(16'h0023);
		wr(8'hA8, 8'h90);
		wait_call();
		rd(8'hE8, 8'h01);
		ret();
		wr(8'hE8, 8'h00);
		ret();
		// two equal-level requests at once go in fixed order
		vq.push_back(16'h0023);
		vq.push_back(16'h002B);
		wr(8'hA8, 8'hB0);
		wr(8'hE8, 8'h03);
		wait_call();
		wr(8'hE8, 8'h02);
		ret();
		wr(8'hE8, 8'h00);
		ret();
		// enable cleared: refused before a multi-cycle, taken before a one-cycle
		clr_race(2'h2);
		vq.push_back(16'h0023);
		clr_race(2'h0);
		// software-set flags on random sources and paces
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			idx = 4'h4 + {1'b0, r[2:0]};
			gap <= r[5:4];
			periph_set <= {9'h000, r[8], 1'b0, r[9]}; // external bits come from pins only
			vq.push_back(16'h0003 + 16'h0008 * {12'h000, idx});
			wr(8'hA8, (idx < 4'h6) ? (8'h80 | (8'h01 << idx)) : 8'h80);
			wr(8'hE6, (idx >= 4'h6) ? (8'h01 << (idx - 4'h6)) : 8'h00);
			wr(8'hE8, 8'h01 << (idx - 4'h4));
			wait_call();
			wr(8'hE8, 8'h00);
			ret();
		end
		// timer 0 flag is one that hardware clears on vectoring
		vq.push_back(16'h000B);
		wr(8'hA8, 8'h82);
		@(posedge sys_clk);
		periph_set <= 12'h002;
		@(posedge sys_clk);
		periph_set <= 12'h000;
		wait_call();
		rd(8'h88, 8'h00);
		ret();
		// external 0: falling edge on a random pin, others held high
		r = $random(seed);
		p = r[2:0];
		wr(8'h88, 8'h01);
		wr(8'hE4, {1'b0, p ^ 3'h1, 1'b0, p});
		wr(8'hA8, 8'h85);
		vq.push_back(16'h0003);
		port_pins <= ~(8'h01 << p);
		wait_call();
		rd(8'h88, 8'h01);
		ret();
		// external 1: active-high level on the neighbour pin
		vq.push_back(16'h0013);
		wr(8'hE4, {1'b1, p ^ 3'h1, 1'b0, p});
		wait_call();
		rd(8'h88, 8'h09);
		port_pins <= 8'h00; // requester lets go before the return
		repeat (2) @(posedge sys_clk); // two synchroniser stages before the flag drops
		rd(8'h88, 8'h01);
		ret();
		repeat (10) @(posedge sys_clk);
		if (vq.size() != 0) chk_vec(16'hFFFF, vq[0]); // a due call never came
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
